// ---- include/rlpc_pkg.sv ----
// Package holding constants and types of the reset and low-power controller.
package rlpc_pkg;
    // Illegal instruction-fetch ranges.
    localparam logic [15:0] RLPC_IO_LO       = 16'h0000;
    localparam logic [15:0] RLPC_IO_HI       = 16'h003F;
    localparam logic [15:0] RLPC_GAP1_LO     = 16'h01C0;
    localparam logic [15:0] RLPC_GAP1_HI     = 16'h023F;
    localparam logic [15:0] RLPC_GAP2_LO     = 16'h0340;
    localparam logic [15:0] RLPC_GAP2_HI     = 16'h0CFF;
    // Oscillator stabilisation delay in processor clock cycles.
    localparam int          RLPC_STAB_CYC    = 4064;
    localparam logic [11:0] RLPC_STAB_LAST   = 12'hFDF;
    // Least pin pulldown time in cycles (three to four, take four).
    localparam logic [2:0]  RLPC_PIN_CYC     = 3'h4;
    // Number of reset sources combined.
    localparam int          RLPC_NSRC        = 5;
    typedef enum logic [1:0] {RLPC_RUN, RLPC_STOP, RLPC_WAIT, RLPC_STAB} rlpc_state_t;
endpackage

// ---- include/rlpc_cnt_if.sv ----
// Interface carrying the stabilisation counter controls and status.
`timescale 1ns/1ps
`default_nettype none
interface rlpc_cnt_if;
    logic        clear;
    logic        run;
    logic        done;
    logic [11:0] count;
    modport ctrl (output clear, output run, input done, input count);
    modport cnt  (input clear, input run, output done, output count);
endinterface
`default_nettype wire

// ---- design/rlpc_stab_counter.sv ----
// Stabilisation delay counter used on stop-mode exit.
`timescale 1ns/1ps
`default_nettype none
module rlpc_stab_counter
    import rlpc_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic rst,
    rlpc_cnt_if.cnt   cif
);
    logic [11:0] count_reg;
    logic [11:0] count_next;

    // Counter holds at zero when cleared and increments while running.
    assign count_next = cif.clear ? 12'h000 : (cif.run ? count_reg + 12'h001 : count_reg);
    assign cif.done   = cif.run && (count_reg == RLPC_STAB_LAST);
    assign cif.count  = count_reg;

    // Counter register.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            count_reg <= 12'h000;
        else
            count_reg <= count_next;
    end
endmodule
`default_nettype wire

// ---- design/rlpc_top.sv ----
// Reset combiner and stop/wait sequencer of the microcontroller.
// Contract
// - Illegal-range instruction fetch raises internal reset.
// - Illegal fetch reset drives reset pin pulldown.
// - Stop with option disabled causes reset.
// - Supply-low reset released after delay on rise.
// - Build option disables supply-low reset entirely.
// - Supply-low reset holds until all sources end.
// - Supply sensing stays active in stop, wait.
// - Any reset terminates stop and wait modes.
// - Stop halts oscillator and liveness watchdog counter.
// - Stop entry disables timer interrupts, clears prescaler.
// - Stop entry clears mask, sets irq enable.
// - Stop leaves all other state untouched.
// - Stop exits only on listed wake sources or reset.
// - Stop exit waits 4064 cycles before resuming.
// - Wait halts processor clock, timers keep running.
// - Wait clears interrupt mask, keeps other state.
// - Wait ends on listed interrupts or reset.
// - Pin pulldown lasts reset or four cycles.
// - Watchdog cleared on stop; held per exit kind.
`timescale 1ns/1ps
`default_nettype none
module rlpc_top
    import rlpc_pkg::*;
#(
    parameter bit STOP_ENABLE     = 1'b1,
    parameter bit SUPPLY_LOW_EN   = 1'b1,
    parameter int SUPPLY_DELAY_CYC = RLPC_STAB_CYC
)
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        fetch_valid,
    input  wire logic [15:0] fetch_addr,
    input  wire logic        stop_exec,
    input  wire logic        wait_exec,
    input  wire logic        supply_below_falling,
    input  wire logic        supply_above_rising,
    input  wire logic        reset_pin_in,
    input  wire logic        watchdog_timeout,
    input  wire logic        irq_pin_req,
    input  wire logic        port_fall_wake,
    input  wire logic        serial_link_receive_pin,
    input  wire logic        timer_irq,
    input  wire logic        spi_irq,
    input  wire logic        gauge_irq,
    output logic             internal_rst,
    output logic             reset_pin_out,
    output logic             reset_pin_oe,
    output logic             osc_enable,
    output logic             cpu_clk_enable,
    output logic             timer_clk_enable,
    output logic             timer_irq_disable,
    output logic             prescaler_clear,
    output logic             ccr_mask_clear,
    output logic             external_irq_enable_set,
    output logic             watchdog_clear,
    output logic             watchdog_hold,
    output logic             stop_active,
    output logic             wait_active
);
    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers for pins and analog detector outputs.
    logic [4:0] sync1_reg;
    logic [4:0] sync2_reg;
    logic [4:0] async_in;
    logic       rxp_d_reg;

    assign async_in = {supply_below_falling, supply_above_rising, reset_pin_in,
                       irq_pin_req, serial_link_receive_pin};

    // Two flip-flops per asynchronous input; only the second stage is read.
    // Reset levels match the idle pins, so no false reset source follows reset.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            sync1_reg <= 5'h0C;
            sync2_reg <= 5'h0C;
        end
        else
        begin
            sync1_reg <= async_in;
            sync2_reg <= sync1_reg;
        end
    end

    logic sup_low_s;
    logic sup_ok_s;
    logic ext_rst_s;
    logic irq_s;
    logic rxp_s;
    assign sup_low_s = sync2_reg[4];
    assign sup_ok_s  = sync2_reg[3];
    assign ext_rst_s = ~sync2_reg[2];
    assign irq_s     = sync2_reg[1];
    assign rxp_s     = sync2_reg[0];

    // Receive-pin edge detector reads the synchronised level only.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            rxp_d_reg <= 1'b0;
        else
            rxp_d_reg <= rxp_s;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Illegal fetch decode.
    function automatic logic rlpc_in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
        rlpc_in_range = (a >= lo) && (a <= hi);
    endfunction

    logic illegal_fetch;
    // A fetch from the I/O page or either unimplemented gap is illegal.
    assign illegal_fetch = fetch_valid && (rlpc_in_range(fetch_addr, RLPC_IO_LO, RLPC_IO_HI)
                         || rlpc_in_range(fetch_addr, RLPC_GAP1_LO, RLPC_GAP1_HI)
                         || rlpc_in_range(fetch_addr, RLPC_GAP2_LO, RLPC_GAP2_HI));

    logic stop_reset;
    // With the stop option off, stop turns into a reset.
    assign stop_reset = stop_exec && !STOP_ENABLE;

    ////////////////////////////////////////////////////////////////////////////
    // Supply-low reset with release delay.
    logic        sl_active_reg;
    logic [12:0] sl_cnt_reg;
    logic        sl_trip;
    // The detector is sampled in every mode, stop and wait included.
    assign sl_trip = SUPPLY_LOW_EN && sup_low_s;

    // Assert on falling threshold, release after delay once supply rises.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            sl_active_reg <= 1'b0;
            sl_cnt_reg    <= 13'h0000;
        end
        else if (sl_trip || (sl_active_reg && !sup_ok_s))
        begin
            sl_active_reg <= 1'b1;
            sl_cnt_reg    <= 13'h0000;
        end
        else if (sl_active_reg)
        begin
            if (sl_cnt_reg == 13'(SUPPLY_DELAY_CYC - 1))
                sl_active_reg <= 1'b0;
            else
                sl_cnt_reg <= sl_cnt_reg + 13'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset combination and pin pulldown.
    logic [RLPC_NSRC-1:0] src_vec;
    logic                 internal_src;
    logic                 rst_reg;
    logic [2:0]           pin_cnt_reg;
    logic                 pin_pull;

    assign src_vec      = {illegal_fetch, stop_reset, sl_active_reg, watchdog_timeout, ext_rst_s};
    // Internal sources only; the pin itself does not re-trigger the pulldown.
    assign internal_src = |src_vec[RLPC_NSRC-1:1];

    // Registered OR of all sources; release only when every one is quiet.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            rst_reg <= 1'b1;
        else
            rst_reg <= |src_vec;
    end

    // Pulldown stretch counter guarantees a four-cycle minimum pulse.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            pin_cnt_reg <= RLPC_PIN_CYC;
        else if (internal_src)
            pin_cnt_reg <= RLPC_PIN_CYC;
        else if (pin_cnt_reg != 3'h0)
            pin_cnt_reg <= pin_cnt_reg - 3'h1;
    end

    // Pulldown active while an internal source lasts or the stretch runs.
    assign pin_pull      = internal_src || (pin_cnt_reg != 3'h0);
    assign reset_pin_out = 1'b0;
    assign reset_pin_oe  = pin_pull;
    assign internal_rst  = rst_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Low-power sequencer.
    rlpc_state_t state_reg;
    rlpc_state_t state_next;
    logic        stab_by_reset_reg;
    logic        stop_wake;
    logic        wait_wake;
    logic        stop_enter;
    logic        wait_enter;
    rlpc_cnt_if  cif ();

    rlpc_stab_counter u_stab (
        .core_clk (core_clk),
        .rst      (rst),
        .cif      (cif)
    );

    // Only the listed pins wake from stop; timers are frozen there.
    assign stop_wake  = irq_s || port_fall_wake || (rxp_s && !rxp_d_reg);
    assign wait_wake  = stop_wake || timer_irq || spi_irq || gauge_irq;
    assign stop_enter = (state_reg == RLPC_RUN) && stop_exec && STOP_ENABLE && !rst_reg;
    assign wait_enter = (state_reg == RLPC_RUN) && wait_exec && !stop_exec && !rst_reg;

    // Next-state selection.
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            RLPC_RUN:  if (stop_enter) state_next = RLPC_STOP;
                       else if (wait_enter) state_next = RLPC_WAIT;
            RLPC_STOP: if (rst_reg || stop_wake) state_next = RLPC_STAB;
            RLPC_WAIT: if (rst_reg || wait_wake) state_next = RLPC_RUN;
            RLPC_STAB: if (cif.done) state_next = RLPC_RUN;
            default:   state_next = RLPC_RUN;
        endcase
    end

    // State and exit-kind registers.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg         <= RLPC_RUN;
            stab_by_reset_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            if (state_reg == RLPC_STOP)
                stab_by_reset_reg <= rst_reg;
        end
    end

    // Counter is held clear outside the stabilisation state and runs through it.
    assign cif.clear = (state_reg != RLPC_STAB);
    assign cif.run   = (state_reg == RLPC_STAB);

    // Oscillator off in stop; processor clock off in stop, wait and recovery.
    assign osc_enable       = (state_reg != RLPC_STOP);
    assign cpu_clk_enable   = (state_reg == RLPC_RUN);
    assign timer_clk_enable = (state_reg != RLPC_STOP);

    // Entry side effects are single-cycle strobes; nothing else is touched.
    assign timer_irq_disable       = stop_enter;
    assign prescaler_clear         = stop_enter;
    assign ccr_mask_clear          = stop_enter || wait_enter;
    assign external_irq_enable_set = stop_enter;

    // Watchdog cleared on stop entry, held through a reset-driven recovery.
    assign watchdog_clear = stop_enter;
    assign watchdog_hold  = (state_reg == RLPC_STOP) || ((state_reg == RLPC_STAB) && stab_by_reset_reg);
    assign stop_active    = (state_reg == RLPC_STOP);
    assign wait_active    = (state_reg == RLPC_WAIT);

    ////////////////////////////////////////////////////////////////////////////
    // Assertions and covers.
    int stab_len;
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            stab_len <= 0;
        else if (state_reg == RLPC_STAB)
            stab_len <= stab_len + 1;
        else
            stab_len <= 0;
    end

    illegal_fetch_rst_a: assert property (@(posedge core_clk) disable iff (rst)
        illegal_fetch |=> internal_rst) else $error("illegal fetch gave no reset");
    illegal_pin_a: assert property (@(posedge core_clk) disable iff (rst)
        illegal_fetch |-> reset_pin_oe) else $error("illegal fetch gave no pulldown");
    stop_disabled_a: assert property (@(posedge core_clk) disable iff (rst)
        stop_reset |=> internal_rst && state_reg != RLPC_STOP) else $error("disabled stop not reset");
    supply_rst_a: assert property (@(posedge core_clk) disable iff (rst)
        sl_trip |=> ##1 internal_rst) else $error("supply low gave no reset");
    pin_stretch_a: assert property (@(posedge core_clk) disable iff (rst)
        $fell(internal_src) |-> reset_pin_oe [*4]) else $error("pulldown too short");
    stab_len_a: assert property (@(posedge core_clk) disable iff (rst)
        (state_reg == RLPC_STAB && cif.done) |-> stab_len == RLPC_STAB_CYC - 1) else $error("stab length wrong");
    reset_exits_a: assert property (@(posedge core_clk) disable iff (rst)
        (rst_reg && state_reg == RLPC_WAIT) |=> state_reg == RLPC_RUN) else $error("reset kept wait");
    stop_fx_a: assert property (@(posedge core_clk) disable iff (rst)
        (state_reg == RLPC_RUN && $past(state_reg) != RLPC_STOP && state_next == RLPC_STOP)
        |-> ccr_mask_clear && external_irq_enable_set && timer_irq_disable) else $error("stop entry effects");
    osc_off_a: assert property (@(posedge core_clk) disable iff (rst)
        stop_active |-> !osc_enable && watchdog_hold) else $error("oscillator on in stop");
    stop_rst_exit_a: assert property (@(posedge core_clk) disable iff (rst)
        (rst_reg && state_reg == RLPC_STOP) |=> state_reg == RLPC_STAB) else $error("reset kept stop");
    rst_follow_a: assert property (@(posedge core_clk) disable iff (rst)
        1'b1 |=> internal_rst == ($past(src_vec) != '0)) else $error("internal reset is not the source OR");
    wait_fx_a: assert property (@(posedge core_clk) disable iff (rst)
        wait_enter |-> ccr_mask_clear && !external_irq_enable_set) else $error("wait entry effects");
    wait_clk_a: assert property (@(posedge core_clk) disable iff (rst)
        wait_active |-> !cpu_clk_enable && timer_clk_enable && osc_enable) else $error("clock gating in wait");

    stop_cycle_c: cover property (@(posedge core_clk) disable iff (rst) state_reg == RLPC_STAB ##1 state_reg == RLPC_RUN);
    wait_cycle_c: cover property (@(posedge core_clk) disable iff (rst) wait_active ##1 !wait_active);
    supply_c:     cover property (@(posedge core_clk) disable iff (rst) $fell(sl_active_reg));
endmodule
`default_nettype wire

// ---- bench/rlpc_cpu_model.sv ----
// Behavioural CPU core that issues fetches and stop or wait instructions.
`timescale 1ns/1ps
`default_nettype none
module rlpc_cpu_model
(
    input  wire logic        core_clk,
    input  wire logic        cpu_clk_enable,
    output logic             fetch_valid,
    output logic [15:0]      fetch_addr,
    output logic             stop_exec,
    output logic             wait_exec
);
    ////////////////////////////////////////////////////////////////////////
    // Idle bus levels at time zero.
    initial
    begin
        fetch_valid = 1'b0;
        fetch_addr  = 16'hFFFF;
        stop_exec   = 1'b0;
        wait_exec   = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // One request for one cycle: 0 fetch, 1 stop, 2 wait.
    // A halted core clock stalls the request, as a real core would.
    task automatic issue(input logic [1:0] kind, input logic [15:0] addr);
        while (cpu_clk_enable !== 1'b1)
            @(negedge core_clk);
        @(negedge core_clk);
        fetch_valid = (kind == 2'h0);
        fetch_addr  = addr;
        stop_exec   = (kind == 2'h1);
        wait_exec   = (kind == 2'h2);
        @(negedge core_clk);
        fetch_valid = 1'b0;
        fetch_addr  = ~addr; // A stale address must never look valid.
        stop_exec   = 1'b0;
        wait_exec   = 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- bench/rlpc_tb_top.sv ----
// Self-checking testbench of the reset and low-power controller.
`timescale 1ns/1ps
`default_nettype none
module rlpc_tb_top;
    import rlpc_pkg::*;
    logic        core_clk, rst, supply_below_falling, supply_above_rising;
    logic        reset_pin_in, watchdog_timeout, serial_link_receive_pin;
    logic        irq_pin_req, port_fall_wake, timer_irq, spi_irq, gauge_irq;
    logic [4:0]  wake;
    logic        fetch_valid, stop_exec, wait_exec;
    logic [15:0] fetch_addr;
    logic        internal_rst, reset_pin_out, reset_pin_oe, osc_enable;
    logic        cpu_clk_enable, timer_clk_enable, timer_irq_disable;
    logic        prescaler_clear, ccr_mask_clear, external_irq_enable_set;
    logic        watchdog_clear, watchdog_hold, stop_active, wait_active;
    logic [4:0]  strobes;
    logic        internal_rst_b, reset_pin_oe_b, stop_active_b;
    int          fails = 0;
    int          checked = 0;
    int          cycles = 0;
    int          n;

    // Wake sources share one vector so scenarios can loop over them.
    assign {gauge_irq, spi_irq, timer_irq, port_fall_wake, irq_pin_req} = wake;
    assign strobes = {ccr_mask_clear, external_irq_enable_set, timer_irq_disable, prescaler_clear, watchdog_clear};

    // Short supply delay keeps the run brief.
    rlpc_top #(.SUPPLY_DELAY_CYC(8)) dut (.*);
    rlpc_cpu_model cpu (.*);

    // Build with stop turned into a reset and no supply-low sensing, as a watchdog user takes it.
    rlpc_top #(.STOP_ENABLE(1'b0), .SUPPLY_LOW_EN(1'b0), .SUPPLY_DELAY_CYC(8)) dut2 (
        .*,
        .internal_rst            (internal_rst_b),
        .reset_pin_out           (),
        .reset_pin_oe            (reset_pin_oe_b),
        .osc_enable              (),
        .cpu_clk_enable          (),
        .timer_clk_enable        (),
        .timer_irq_disable       (),
        .prescaler_clear         (),
        .ccr_mask_clear          (),
        .external_irq_enable_set (),
        .watchdog_clear          (),
        .watchdog_hold           (),
        .stop_active             (stop_active_b),
        .wait_active             ()
    );

    ////////////////////////////////////////////////////////////////////////
    // Clock of 40 ns.
    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // Hang guard; four stop recoveries need about 17000 cycles.
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            fails++;
            tally_and_finish();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(negedge core_clk);
    endtask

    // Bounded wait for a level; n holds the cycles spent.
    task automatic settle(ref logic s, input logic v, input int lim);
        n = 0;
        while (s !== v && n < lim)
        begin
            tick(1);
            n++;
        end
    endtask

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic test_reset();
        tick(10);
        rst = 1'b0;
        tick(1);
        chk({internal_rst, reset_pin_out, reset_pin_oe}, 3'h1);
        tick(2);
        chk({internal_rst, reset_pin_oe}, 2'h1);
        tick(4);
        chk({internal_rst, reset_pin_oe}, 2'h0);
        $display("Reset test done");
    endtask

    // Both edges of every illegal range, and their legal neighbours except the one just below the second gap.
    task automatic test_fetch();
        logic [15:0] addr [10] = '{16'h0000, 16'h003F, 16'h0040, 16'h01BF, 16'h01C0,
                                   16'h023F, 16'h0240, 16'h0340, 16'h0CFF, 16'h0D00};
        logic [9:0]  bad = 10'h1B3;
        for (int i = 0; i < 10; i++)
        begin
            cpu.issue(2'h0, addr[i]);
            chk({internal_rst, reset_pin_oe}, {2{bad[i]}});
            tick(8);
            chk({internal_rst, reset_pin_oe}, 2'h0);
        end
        $display("Fetch test done");
    endtask

    // Stop entry, ignored wake sources, then each stop wake source.
    task automatic test_stop();
        for (int k = 0; k < 3; k++)
        begin
            fork
                cpu.issue(2'h1, 16'h0000);
                begin
                    @(negedge core_clk);
                    #1;
                    chk(strobes, 5'h1F);
                end
            join
            chk({stop_active, osc_enable, cpu_clk_enable, watchdog_hold, strobes}, 9'h120);
            chk({internal_rst_b, reset_pin_oe_b, stop_active_b}, 3'h6);
            wake = 5'h1C;
            tick(4);
            chk(stop_active, 1'b1);
            wake = (k == 2) ? 5'h00 : 5'h01 << k;
            serial_link_receive_pin = (k == 2);
            settle(stop_active, 1'b0, 8);
            wake = 5'h00;
            serial_link_receive_pin = 1'b0;
            chk({stop_active, osc_enable, watchdog_hold, cpu_clk_enable}, 4'h4);
            settle(cpu_clk_enable, 1'b1, 4200);
            chk(16'(n), 16'(RLPC_STAB_CYC));
            tick(4);
        end
        $display("Stop test done");
    endtask

    // Wait entry and each wait wake source in turn, except the receive-pin edge.
    task automatic test_wait();
        for (int k = 0; k < 5; k++)
        begin
            fork
                cpu.issue(2'h2, 16'h0000);
                begin
                    @(negedge core_clk);
                    #1;
                    chk(strobes, 5'h10);
                end
            join
            chk({wait_active, cpu_clk_enable, timer_clk_enable, osc_enable}, 4'hB);
            wake = 5'h01 << k;
            settle(wait_active, 1'b0, 6);
            chk({wait_active, cpu_clk_enable}, 2'h1);
            wake = 5'h00;
            tick(6);
        end
        $display("Wait test done");
    endtask

    // Supply drop in wait mode, overlapped by a watchdog reset.
    task automatic test_supply();
        cpu.issue(2'h2, 16'h0000);
        supply_above_rising = 1'b0;
        supply_below_falling = 1'b1;
        settle(internal_rst, 1'b1, 6);
        tick(1);
        chk({internal_rst, reset_pin_oe, wait_active}, 3'h6);
        chk(internal_rst_b, 1'b0);
        supply_below_falling = 1'b0;
        tick(12);
        chk(internal_rst, 1'b1);
        supply_above_rising = 1'b1;
        tick(6);
        chk(internal_rst, 1'b1);
        watchdog_timeout = 1'b1;
        tick(14);
        chk(internal_rst, 1'b1);
        watchdog_timeout = 1'b0;
        tick(2);
        chk(internal_rst, 1'b0);
        $display("Supply test done");
    endtask

    // An external reset ends stop mode; the watchdog is frozen in stop, so it cannot.
    task automatic test_stop_reset();
        cpu.issue(2'h1, 16'h0000);
        reset_pin_in = 1'b0;
        tick(4);
        reset_pin_in = 1'b1;
        chk({internal_rst, watchdog_hold, stop_active}, 3'h6);
        settle(stop_active, 1'b0, 4);
        chk(stop_active, 1'b0);
        settle(cpu_clk_enable, 1'b1, 4200);
        chk({cpu_clk_enable, watchdog_hold}, 2'h2);
        $display("Stop reset test done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial
    begin
        rst = 1'b1;
        supply_below_falling = 1'b0;
        supply_above_rising = 1'b1;
        reset_pin_in = 1'b1;
        watchdog_timeout = 1'b0;
        serial_link_receive_pin = 1'b0;
        wake = 5'h00;
        test_reset();
        test_fetch();
        test_stop();
        test_wait();
        test_supply();
        test_stop_reset();
        tally_and_finish();
    end
endmodule
`default_nettype wire
